//--- verilog/tdmf_pkg.sv
// package: frame geometry, field positions and carrier types for the tdm slave framer
package tdmf_pkg;
  // =====================================================================
  // frame geometry
  localparam int FRAME_HZ         = 8000;
  localparam int TERM_CHANNELS    = 3;
  localparam int LINE_CHANNELS    = 8;
  localparam int BYTES_PER_CHAN   = 4;
  localparam int TERM_FRAME_BITS  = 96;
  localparam int LINE_FRAME_BITS  = 256;
  localparam int TERM_RATE_KBPS   = 768;
  localparam int LINE_RATE_KBPS   = 2048;
  localparam int BIT_CNT_W        = 9;
  localparam logic [1:0] BYTE_B1  = 2'h0;
  localparam logic [1:0] BYTE_B2  = 2'h1;
  localparam logic [1:0] BYTE_MON = 2'h2;
  localparam logic [1:0] BYTE_CI  = 2'h3;
  localparam logic [1:0] TERM_OWN_CHAN = 2'h1;
  localparam logic [2:0] BIT_MSB  = 3'h7;
  localparam logic [2:0] BIT_LSB  = 3'h0;
  // fourth byte: command/indicate 7..2 (D bits 7..6 in digital line mode), monitor receive 1, monitor transmit 0
  localparam int CI_W             = 6;
  localparam int CI_FIELD_LO      = 2;
  localparam int MR_POS           = 1;
  localparam int MX_POS           = 0;
  // =====================================================================
  // monitor address byte layout
  localparam int ADDR_MARK_POS    = 7;
  localparam int ADDR_SLOT_HI     = 6;
  localparam int ADDR_SLOT_LO     = 4;
  localparam int ADDR_PAIR_POS    = 3;
  localparam logic [2:0] ADDR_LOW_ZERO = 3'h0;
  // =====================================================================
  // command/indicate output control codes
  localparam logic [2:0] CI_CODE_OFF    = 3'h0;
  localparam logic [2:0] CI_CODE_DIRECT = 3'h7;
  localparam logic [2:0] CI_CODE_ONE    = 3'h1;
  localparam int STATUS_CI_LO     = 2;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [5:0] CI_ALL_ONES = 6'h3f;
  // =====================================================================
  // carriers
  typedef struct packed {
    logic [2:0] slotAddr;
    logic       pairSel;
  } tdmf_addr_t;
  typedef struct packed {
    logic       terminalFraming;
    logic       analogueLine;
    logic [2:0] ciCode;
  } tdmf_cfg_t;
  typedef struct packed {
    logic [BIT_CNT_W-1:0] bitIdx;
    logic                 valid;
  } tdmf_pos_t;

  function automatic logic [7:0] addr_byte(input tdmf_addr_t a);
    addr_byte = {1'b1, a.slotAddr, a.pairSel, ADDR_LOW_ZERO};
  endfunction : addr_byte
endpackage : tdmf_pkg

//--- verilog/tdmf_sync2.sv
// two-flop synchroniser for asynchronous pin inputs
module tdmf_sync2
  import tdmf_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] dout_nxt;

  always_comb begin
    meta_nxt = clkEn ? din : meta_r;
    dout_nxt = clkEn ? meta_r : dout;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end
endmodule : tdmf_sync2

//--- verilog/tdmf_ci_enc.sv
// command/indicate field encoder from control code, status and mask
module tdmf_ci_enc
  import tdmf_pkg::*;
(
  input  wire logic [2:0]      ciCode,
  input  wire logic [7:0]      statusBits,
  input  wire logic [7:0]      maskBits,
  output logic      [CI_W-1:0] ciOut
);
  logic [7:0] pending;
  logic [2:0] bitSel;

  always_comb begin
    pending = statusBits & maskBits;
    bitSel  = ciCode - CI_CODE_ONE;
    ciOut   = CI_ALL_ONES;
    if (ciCode == CI_CODE_OFF) begin
      ciOut = CI_ALL_ONES;
    end else if (ciCode == CI_CODE_DIRECT) begin
      // masked positions stay low because the and already clears them
      ciOut = pending[7:STATUS_CI_LO];
    end else if (|pending) begin
      ciOut[bitSel] = 1'b0;
    end
  end
endmodule : tdmf_ci_enc

//--- verilog/tdmf_framer.sv
// slave frame, slot and channel logic for a four-wire time-multiplexed serial bus
// =====================================================================
// module
module tdmf_framer
  import tdmf_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            clkEn,
  input  wire logic            busClk,
  input  wire logic            frameSync,
  input  wire logic            dataDownIn,
  input  wire logic            dataUpIn,
  output logic                 dataUpOut,
  output logic                 dataUpOe_n,
  input  wire logic            slot_addr_bit0,
  input  wire logic            slot_addr_bit1,
  input  wire logic            slot_addr_bit2,
  input  wire logic            pair_select_pin,
  input  wire tdmf_cfg_t       bus_control_register,
  input  wire logic [7:0]      statusBits,
  input  wire logic [7:0]      maskBits,
  input  wire logic            monReplyValid,
  input  wire logic [7:0]      monReplyByte,
  output logic                 monRxStrobe,
  output logic [7:0]           monRxByte,
  output logic                 monRxAddrHit,
  output logic                 monRxMx_n,
  output logic                 monTxAck,
  output logic [CI_W-1:0]      ciRxField,
  output logic [7:0]           b1RxByte,
  output logic [7:0]           b2RxByte,
  output logic                 frameLock
);
  // =====================================================================
  // pin synchronisation
  localparam int PIN_W = 7;
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinSync;
  logic             clkS;
  logic             fsS;
  logic             ddS;
  tdmf_addr_t       ownAddr;
  logic             duS;

  assign pinRaw = {busClk, frameSync, dataDownIn, slot_addr_bit2, slot_addr_bit1,
                   slot_addr_bit0, pair_select_pin};

  tdmf_sync2 #(.W(PIN_W)) uSync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .din     (pinRaw),
    .dout    (pinSync)
  );

  tdmf_sync2 #(.W(1)) uSyncUp (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .din     (dataUpIn),
    .dout    (duS)
  );

  assign clkS             = pinSync[6];
  assign fsS              = pinSync[5];
  assign ddS              = pinSync[4];
  assign ownAddr.slotAddr = pinSync[3:1];
  assign ownAddr.pairSel  = pinSync[0];

  // =====================================================================
  // edge detection and bit framing
  // the bus clock runs at twice the bit rate: a bit spans two bus clocks,
  // so a half-bit phase toggles on each rising edge
  logic                 clkD_r, clkD_nxt;
  logic                 fsD_r, fsD_nxt;
  logic                 phase_r, phase_nxt;
  logic [BIT_CNT_W-1:0] bitCnt_r, bitCnt_nxt;
  logic                 lock_r, lock_nxt;
  logic                 launch_r, launch_nxt;
  logic                 clkRise;
  logic                 clkFall;
  logic                 fsRise;
  logic                 sampleTick;
  logic                 launchTick;
  logic [BIT_CNT_W-1:0] frameBits;

  assign clkRise   = clkS & ~clkD_r;
  assign clkFall   = ~clkS & clkD_r;
  assign fsRise    = fsS & ~fsD_r;
  assign frameBits = bus_control_register.terminalFraming ? BIT_CNT_W'(TERM_FRAME_BITS)
                                                          : BIT_CNT_W'(LINE_FRAME_BITS);
  // sample on the first falling edge of a bit; launch one cycle after the rise that starts
  // a bit, so the counter already points at the bit being launched
  assign sampleTick = clkFall & phase_r;
  assign launchTick = launch_r;

  always_comb begin
    launch_nxt = clkRise & (fsRise | ~phase_r);
    clkD_nxt   = clkS;
    fsD_nxt    = fsS;
    phase_nxt  = phase_r;
    bitCnt_nxt = bitCnt_r;
    lock_nxt   = lock_r;
    if (clkRise) begin
      if (fsS && !fsD_r) begin
        // frame start aligns phase and bit count
        phase_nxt  = 1'b1;
        bitCnt_nxt = '0;
        lock_nxt   = 1'b1;
      end else begin
        phase_nxt = ~phase_r;
        if (!phase_r) begin
          if (bitCnt_r == frameBits - BIT_CNT_W'(1)) begin
            bitCnt_nxt = '0;
          end else begin
            bitCnt_nxt = bitCnt_r + BIT_CNT_W'(1);
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkD_r   <= 1'b0;
      fsD_r    <= 1'b0;
      phase_r  <= 1'b0;
      bitCnt_r <= '0;
      lock_r   <= 1'b0;
      launch_r <= 1'b0;
    end else if (clkEn) begin
      launch_r <= launch_nxt;
      clkD_r   <= clkD_nxt;
      fsD_r    <= fsD_nxt;
      phase_r  <= phase_nxt;
      bitCnt_r <= bitCnt_nxt;
      lock_r   <= lock_nxt;
    end
  end

  // =====================================================================
  // position decode: channel, byte in channel, bit in byte
  logic [2:0] chanIdx;
  logic [1:0] byteIdx;
  logic [2:0] bitInByte;
  logic       ownChan;

  assign chanIdx   = bitCnt_r[7:5];
  assign byteIdx   = bitCnt_r[4:3];
  assign bitInByte = BIT_MSB - bitCnt_r[2:0];
  // terminal mode owns channel 1 only; line mode owns the addressed slot
  assign ownChan   = bus_control_register.terminalFraming ? (chanIdx == {1'b0, TERM_OWN_CHAN})
                                                          : (chanIdx == ownAddr.slotAddr);

  // =====================================================================
  // receive shift and monitor handling
  logic [7:0]      shift_r, shift_nxt;
  logic [7:0]      monRx_r, monRx_nxt;
  logic            monStb_r, monStb_nxt;
  logic            first_r, first_nxt;
  logic            hit_r, hit_nxt;
  logic            mxIn_r, mxIn_nxt;
  logic            mxPrev_r, mxPrev_nxt;
  logic            mrIn_r, mrIn_nxt;
  logic            mrPrev_r, mrPrev_nxt;
  logic            ack_r, ack_nxt;
  logic [CI_W-1:0] ciRx_r, ciRx_nxt;
  logic [7:0]      b1_r, b1_nxt;
  logic [7:0]      b2_r, b2_nxt;
  logic [7:0]      rxByte;
  logic            byteDone;

  assign rxByte   = {shift_r[6:0], ddS};
  assign byteDone = sampleTick & lock_r & ownChan & (bitInByte == BIT_LSB);

  always_comb begin
    shift_nxt  = shift_r;
    monRx_nxt  = monRx_r;
    monStb_nxt = 1'b0;
    first_nxt  = first_r;
    hit_nxt    = hit_r;
    mxIn_nxt   = mxIn_r;
    mxPrev_nxt = mxPrev_r;
    mrIn_nxt   = mrIn_r;
    mrPrev_nxt = mrPrev_r;
    ack_nxt    = 1'b0;
    ciRx_nxt   = ciRx_r;
    b1_nxt     = b1_r;
    b2_nxt     = b2_r;
    if (sampleTick) begin
      shift_nxt = rxByte;
    end
    // channel 0 of a terminal frame, with its monitor byte, is never looked at
    if (byteDone) begin
      unique case (byteIdx)
        BYTE_B1: b1_nxt = rxByte;
        BYTE_B2: b2_nxt = rxByte;
        BYTE_MON: monRx_nxt = rxByte;
        BYTE_CI: begin
          // D bits 7..6 are captured with the command/indicate field
          ciRx_nxt   = rxByte[CI_FIELD_LO+CI_W-1:CI_FIELD_LO];
          mxIn_nxt   = rxByte[MX_POS];
          mrIn_nxt   = rxByte[MR_POS];
          mxPrev_nxt = mxIn_r;
          mrPrev_nxt = mrIn_r;
          // new byte offered: master pulls transmit low after it was high
          if (!rxByte[MX_POS] && mxIn_r) begin
            monStb_nxt = 1'b1;
            if (first_r) begin
              hit_nxt = (monRx_r == addr_byte(ownAddr));
            end
            first_nxt = 1'b0;
          end
          // transmit high two frames running ends the message
          if (rxByte[MX_POS] && mxIn_r) begin
            first_nxt = 1'b1;
            hit_nxt   = 1'b0;
          end
          // receive bit rising acknowledges our reply byte
          ack_nxt = rxByte[MR_POS] & ~mrIn_r;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r  <= '0;
      monRx_r  <= IDLE_BYTE;
      monStb_r <= 1'b0;
      first_r  <= 1'b1;
      hit_r    <= 1'b0;
      mxIn_r   <= 1'b1;
      mxPrev_r <= 1'b1;
      mrIn_r   <= 1'b0;
      mrPrev_r <= 1'b0;
      ack_r    <= 1'b0;
      ciRx_r   <= CI_ALL_ONES;
      b1_r     <= IDLE_BYTE;
      b2_r     <= IDLE_BYTE;
    end else if (clkEn) begin
      shift_r  <= shift_nxt;
      monRx_r  <= monRx_nxt;
      monStb_r <= monStb_nxt;
      first_r  <= first_nxt;
      hit_r    <= hit_nxt;
      mxIn_r   <= mxIn_nxt;
      mxPrev_r <= mxPrev_nxt;
      mrIn_r   <= mrIn_nxt;
      mrPrev_r <= mrPrev_nxt;
      ack_r    <= ack_nxt;
      ciRx_r   <= ciRx_nxt;
      b1_r     <= b1_nxt;
      b2_r     <= b2_nxt;
    end
  end

  // =====================================================================
  // upstream transmit
  logic [CI_W-1:0] ciTx;
  logic [7:0]      txByte;
  logic            txBit;
  logic            txEn;
  logic            duOut_r, duOut_nxt;
  logic            duOe_r, duOe_nxt;

  tdmf_ci_enc uCi (
    .ciCode     (bus_control_register.ciCode),
    .statusBits (statusBits),
    .maskBits   (maskBits),
    .ciOut      (ciTx)
  );

  always_comb begin
    txByte = IDLE_BYTE;
    txEn   = 1'b0;
    unique case (byteIdx)
      // monitor reply only inside an exchange the master addressed to us
      BYTE_MON: if (hit_r && monReplyValid) begin
        txByte = monReplyByte;
        txEn   = 1'b1;
      end
      BYTE_CI: begin
        txEn = 1'b1;
        txByte[CI_FIELD_LO+CI_W-1:CI_FIELD_LO] = ciTx;
        // D field stays released in digital line mode
        if (!bus_control_register.terminalFraming && !bus_control_register.analogueLine) begin
          txByte[7:6] = 2'h3;
        end
        txByte[MX_POS] = ~(hit_r & monReplyValid);
      end
      default: ;
    endcase
  end

  assign txBit = txByte[bitInByte];

  always_comb begin
    duOut_nxt = duOut_r;
    duOe_nxt  = duOe_r;
    if (!lock_r) begin
      duOut_nxt = 1'b1;
      duOe_nxt  = 1'b1;
    end else if (launchTick) begin
      duOut_nxt = txBit;
      // drive only our own channel and only the bytes we use
      duOe_nxt  = ~(ownChan & txEn & ~txBit);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      duOut_r <= 1'b1;
      duOe_r  <= 1'b1;
    end else if (clkEn) begin
      duOut_r <= duOut_nxt;
      duOe_r  <= duOe_nxt;
    end
  end

  assign dataUpOut    = duOut_r;
  assign dataUpOe_n   = duOe_r;
  assign monRxStrobe  = monStb_r;
  assign monRxByte    = monRx_r;
  assign monRxAddrHit = hit_r;
  assign monRxMx_n    = mxIn_r;
  assign monTxAck     = ack_r;
  assign ciRxField    = ciRx_r;
  assign b1RxByte     = b1_r;
  assign b2RxByte     = b2_r;
  assign frameLock    = lock_r;

  // =====================================================================
  // checks
  property p_bit_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
    (bitCnt_r == frameBits - BIT_CNT_W'(1) && clkRise && !phase_r && !fsRise && clkEn)
      |=> bitCnt_r == '0;
  endproperty
  a_bit_wrap: assert property (p_bit_wrap) else $error("bit counter missed wrap");

  property p_fs_align;
    @(posedge ref_clk) disable iff (!rst_n)
    (clkRise && fsRise && clkEn) |=> (bitCnt_r == '0 && phase_r && lock_r);
  endproperty
  a_fs_align: assert property (p_fs_align) else $error("frame sync did not realign");

  property p_release_out;
    @(posedge ref_clk) disable iff (!rst_n)
    (launchTick && clkEn && lock_r && !ownChan) |=> dataUpOe_n;
  endproperty
  a_release_out: assert property (p_release_out) else $error("drove outside own slot");

  property p_no_unsolicited;
    @(posedge ref_clk) disable iff (!rst_n)
    (launchTick && clkEn && byteIdx == BYTE_MON && !hit_r) |=> dataUpOe_n;
  endproperty
  a_no_unsolicited: assert property (p_no_unsolicited) else $error("monitor driven unasked");

  property p_ci_off;
    @(posedge ref_clk) disable iff (!rst_n)
    (bus_control_register.ciCode == CI_CODE_OFF) |-> ciTx == CI_ALL_ONES;
  endproperty
  a_ci_off: assert property (p_ci_off) else $error("code 000 not all ones");

  property p_ci_direct_mask;
    @(posedge ref_clk) disable iff (!rst_n)
    (bus_control_register.ciCode == CI_CODE_DIRECT)
      |-> (ciTx & ~maskBits[7:STATUS_CI_LO]) == '0;
  endproperty
  a_ci_direct_mask: assert property (p_ci_direct_mask) else $error("masked bit not zero");

  property p_ci_single;
    @(posedge ref_clk) disable iff (!rst_n)
    (bus_control_register.ciCode != CI_CODE_OFF && bus_control_register.ciCode != CI_CODE_DIRECT
     && |(statusBits & maskBits)) |-> $countones(~ciTx) == 1;
  endproperty
  a_ci_single: assert property (p_ci_single) else $error("request not on one bit");

  property p_hit_needs_first;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(hit_r) |-> $past(first_r) && $past(monRx_r) == addr_byte(ownAddr);
  endproperty
  a_hit_needs_first: assert property (p_hit_needs_first) else $error("bad address match");
endmodule : tdmf_framer

//--- test/tdmf_master_model.sv
// behavioural upstream master: frame sync, bus clock at twice the bit rate, downstream data, upstream sampling
module tdmf_master_model (
  output logic      busClk,
  output logic      frameSync,
  output logic      dataDownIn,
  input  wire logic dataUpWire
);
  timeunit 1ns;
  timeprecision 100ps;

  // =====================================================================
  // idle levels
  // clock stands low between frames, as on a deactivated bus
  initial begin
    busClk = 1'b0;
    frameSync = 1'b0;
    dataDownIn = 1'b1;
  end

  // =====================================================================
  // one frame, bit i of the vectors is the i-th bit on the wire
  task automatic run_frame(input int nBits, input logic [255:0] down, output logic [255:0] up);
    up = '1;
    // odd offset keeps link edges off the system clock edges
    #3;
    for (int i = 0; i < nBits; i++) begin
      frameSync = (i == 0);
      dataDownIn = down[i];
      busClk = 1'b1;
      #40;
      busClk = 1'b0;
      #40;
      busClk = 1'b1;
      frameSync = 1'b0;
      #40;
      busClk = 1'b0;
      // sample late in the bit, the slave's drive lags the bit start
      up[i] = dataUpWire;
      #40;
    end
    // released line shows the inverse so a stale value cannot match by luck
    dataDownIn = ~dataDownIn;
  endtask : run_frame
endmodule : tdmf_master_model

//--- test/tb_top.sv
// self-checking bench for the tdm slave framer
module tb_top
  import tdmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // =====================================================================
  // signals
  logic       ref_clk, rst_n, busClk, frameSync, dataDownIn, dataUpOut, dataUpOe_n, upWire;
  logic [2:0] slotSel;
  logic       pairSel, monReplyValid, monRxStrobe, monRxAddrHit, monRxMx_n, frameLock;
  logic       monTxAck;
  logic       lastMr = 1'b0;
  logic [7:0] ackCnt = 8'h00;
  logic [7:0] expAcks = 8'h00;
  tdmf_cfg_t  cfg;
  logic [7:0] statusBits, maskBits, monReplyByte, monRxByte, b1RxByte, b2RxByte;
  logic [5:0] ciRxField;
  logic [7:0] strobeCnt = 8'h00;
  logic [7:0] expStrobes = 8'h00;
  int         miscompares = 0;
  int         comparisons = 0;
  integer     seed = 41;
  logic       hitExp = 1'b0;
  logic       ended = 1'b1;
  logic       lastMx = 1'b1;
  int         highRun = 0;

  // open drain upstream wire with pull-up
  assign upWire = dataUpOe_n ? 1'b1 : dataUpOut;

  tdmf_framer tdmf_framer_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1), .busClk(busClk), .frameSync(frameSync),
    .dataDownIn(dataDownIn), .dataUpIn(upWire), .dataUpOut(dataUpOut),
    .dataUpOe_n(dataUpOe_n), .slot_addr_bit0(slotSel[0]), .slot_addr_bit1(slotSel[1]),
    .slot_addr_bit2(slotSel[2]), .pair_select_pin(pairSel), .bus_control_register(cfg),
    .statusBits(statusBits), .maskBits(maskBits), .monReplyValid(monReplyValid),
    .monReplyByte(monReplyByte), .monRxStrobe(monRxStrobe), .monRxByte(monRxByte),
    .monRxAddrHit(monRxAddrHit), .monRxMx_n(monRxMx_n), .monTxAck(monTxAck),
    .ciRxField(ciRxField),
    .b1RxByte(b1RxByte), .b2RxByte(b2RxByte), .frameLock(frameLock)
  );

  tdmf_master_model tdmf_master_model_i (
    .busClk(busClk), .frameSync(frameSync), .dataDownIn(dataDownIn), .dataUpWire(upWire)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (monRxStrobe === 1'b1) strobeCnt <= strobeCnt + 8'h01;
    if (monTxAck === 1'b1) ackCnt <= ackCnt + 8'h01;
  end

  // =====================================================================
  // expectations and comparisons
  function automatic logic [7:0] own_addr();
    return {1'b1, slotSel, pairSel, 3'h0};
  endfunction : own_addr

  function automatic logic [5:0] exp_ci(input logic [2:0] c, input logic [7:0] st, mk);
    logic [5:0] r;
    r = 6'h3f;
    if (c == 3'h7) r = st[7:2] & mk[7:2];
    else if (c != 3'h0 && (st & mk) != 8'h00) r[c - 3'h1] = 1'b0;
    return r;
  endfunction : exp_ci

  function automatic logic [255:0] put(input logic [255:0] f, input int base, input logic [7:0] b);
    for (int k = 0; k < 8; k++) f[base + k] = b[7 - k];
    return f;
  endfunction : put

  task automatic cmp_frame(input logic [255:0] got, exp, care);
    comparisons++;
    if (((got ^ exp) & care) !== 256'h0) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & care, exp & care);
    end
  endtask : cmp_frame

  task automatic cmp_val(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic results;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // =====================================================================
  // one frame with own channel content, then all checks on it
  task automatic run(input logic [7:0] mon, input logic mxLow);
    logic [255:0] down, up, expUp, care, careCi;
    logic [7:0]   b1, b2, fourth;
    logic [5:0]   ci;
    logic         drive;
    int           nBits, base;
    repeat (4) @(posedge ref_clk);
    nBits = cfg.terminalFraming ? 96 : 256;
    base = cfg.terminalFraming ? 32 : 32 * int'(slotSel);
    for (int w = 0; w < 8; w++) down[w*32 +: 32] = $random(seed);
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    fourth = 8'($random(seed));
    fourth[0] = ~mxLow;
    // channel 0 monitor carries our address; its fourth byte stays random
    if (cfg.terminalFraming) down = put(down, 16, own_addr());
    down = put(put(put(put(down, base, b1), base + 8, b2), base + 16, mon), base + 24, fourth);
    drive = hitExp && monReplyValid;
    ci = exp_ci(cfg.ciCode, statusBits, maskBits);
    expUp = '1;
    care = '1;
    careCi = '0;
    if (drive) expUp = put(expUp, base + 16, monReplyByte);
    if (cfg.terminalFraming || cfg.analogueLine) begin
      for (int k = 0; k < 6; k++) expUp[base + 24 + k] = ci[5 - k];
      careCi[base + 24 +: 6] = 6'h3f;
    end else begin
      care[base + 26 +: 4] = 4'h0;
    end
    care[base + 30] = 1'b0;
    expUp[base + 31] = ~drive;
    tdmf_master_model_i.run_frame(nBits, down, up);
    repeat (20) @(posedge ref_clk);
    cmp_frame(up, expUp, careCi);
    cmp_frame(up, expUp, care & ~careCi);
    cmp_val(b1RxByte, b1);
    cmp_val(b2RxByte, b2);
    cmp_val(monRxByte, mon);
    cmp_val({2'h0, ciRxField}, {2'h0, fourth[7:2]});
    cmp_val({7'h0, monRxMx_n}, {7'h0, fourth[0]});
    cmp_val({7'h0, frameLock}, 8'h01);
    if (mxLow && lastMx) expStrobes++;
    if (fourth[1] && !lastMr) expAcks++;
    lastMr = fourth[1];
    cmp_val(ackCnt, expAcks);
    if (!mxLow) begin
      highRun++;
      if (highRun >= 2) begin
        hitExp = 1'b0;
        ended = 1'b1;
      end
    end else begin
      if (ended) hitExp = (mon == own_addr());
      ended = 1'b0;
      highRun = 0;
    end
    lastMx = ~mxLow;
    cmp_val({7'h0, monRxAddrHit}, {7'h0, hitExp});
    cmp_val(strobeCnt, expStrobes);
  endtask : run

  // =====================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    slotSel = 3'h2;
    pairSel = 1'b1;
    cfg = '{terminalFraming: 1'b1, analogueLine: 1'b0, ciCode: 3'h0};
    statusBits = 8'h00;
    maskBits = 8'h00;
    monReplyValid = 1'b0;
    monReplyByte = 8'h00;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      cfg.ciCode <= 3'(i);
      statusBits <= (i == 15) ? 8'hff : (i == 9) ? 8'h00 : 8'($random(seed));
      maskBits <= (i == 15) ? 8'h00 : (i == 7) ? 8'hff : 8'($random(seed));
      run(8'($random(seed)), 1'b0);
    end
    run(own_addr() ^ 8'h08, 1'b1);
    run(8'hff, 1'b0);
    run(8'hff, 1'b0);
    run(own_addr(), 1'b1);
    monReplyValid <= 1'b1;
    monReplyByte <= 8'($random(seed));
    run(8'($random(seed)), 1'b0);
    run(8'($random(seed)), 1'b1);
    run(8'($random(seed)), 1'b0);
    run(8'($random(seed)), 1'b0);
    run(8'($random(seed)), 1'b0);
    monReplyValid <= 1'b0;
    // line-card framing: random slot, both fourth-byte layouts, then last slot addressed
    @(posedge ref_clk);
    slotSel <= 3'($random(seed));
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      cfg <= '{terminalFraming: 1'b0, analogueLine: i[0], ciCode: 3'($random(seed))};
      statusBits <= 8'($random(seed));
      maskBits <= 8'($random(seed));
      run(8'($random(seed)), 1'b0);
    end
    slotSel <= 3'h7;
    run(8'hff, 1'b0);
    run(own_addr(), 1'b1);
    monReplyValid <= 1'b1;
    run(8'($random(seed)), 1'b0);
    results();
  end

  // about 70k cycles of traffic expected; 90k means a hang
  initial begin
    #900000;
    miscompares++;
    results();
  end
endmodule : tb_top
